// [include/mdc_pkg.sv]
// Functional notes
// - Serial out open drain at 0, push-pull at 1; resets 1.
// - Edge rate field picks 25, 50, 125 or 200 V/us slew; resets 0.
// - PWM scheme: six-input, six with limit, three-input, three with limit.
// - Writing 1 to fault clear clears latched faults; the bit returns to 0.
// - Full-duty frequency bit picks 20 kHz at 0 and 40 kHz at 1.
// - Overvoltage threshold bit picks 34 V at 0 and 22 V at 1.
// - Overvoltage guard off at 0, on at 1; resets 1.
// - Serial errors reach fault pin at 0, not at 1; resets 1.
// - Thermal warnings kept off fault pin at 0, shown at 1; resets 0.
// - Driver shutoff at 1 puts all power transistors in high impedance.
// - Cycle clear bit at 1 clears overcurrent shutdown, not the report, on a PWM cycle change.
// - Filter field picks 0.2, 0.6, 1.25 or 1.6 us deglitch; resets 1.
// - Retry bit picks 5 ms at 0 and 500 ms at 1 after overcurrent.
// - Overcurrent threshold bit picks 16 A at 0 and 24 A at 1.
// - Response: latched, auto retry, report only, or ignored.
// - Recirculation via transistors at 0, diodes at 1.
// - Async rectification off at 0, on at 1.
// - Sync rectification off at 0, on at 1.
// - Sense gain field picks 0.15, 0.3, 0.6 or 1.2 V/A; resets 0.
// - Register at 5h resets to 46h, top bit reads zero, reserved bits kept.
// - Lock code 110b blocks writes except lock field; 011b unlocks.
package mdc_pkg;
  // Register map
  localparam logic [5:0] ADDR_LOCK = 6'h03;
  localparam logic [5:0] ADDR_DRIVE = 6'h04;
  localparam logic [5:0] ADDR_PROT = 6'h05;
  localparam logic [5:0] ADDR_OCP = 6'h06;
  localparam logic [5:0] ADDR_RECIR = 6'h07;
  localparam logic [7:0] RST_DRIVE = 8'h60;
  localparam logic [7:0] RST_PROT = 8'h46;
  localparam logic [7:0] RST_OCP = 8'h10;
  localparam logic [7:0] RST_RECIR = 8'h00;
  localparam logic [7:0] WMASK_DRIVE = 8'hfe;
  localparam logic [7:0] WMASK_PROT = 8'h7f;
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  // Field positions
  localparam int DRV_SDO_BIT = 5;
  localparam int DRV_SLEW_LSB = 3;
  localparam int DRV_PWM_LSB = 1;
  localparam int DRV_CLR_BIT = 0;
  localparam int PROT_FULL_BIT = 4;
  localparam int PROT_OVSEL_BIT = 3;
  localparam int PROT_OVEN_BIT = 2;
  localparam int PROT_SERR_BIT = 1;
  localparam int PROT_OTW_BIT = 0;
  localparam int OCP_OFF_BIT = 7;
  localparam int OVERCURRENT_CYCLE_CLEAR_BIT = 6;
  localparam int OVERCURRENT_FILTER_TIME_LSB = 4;
  localparam int OVERCURRENT_RETRY_INTERVAL_BIT = 3;
  localparam int OVERCURRENT_THRESHOLD_BIT = 2;
  localparam int OVERCURRENT_RESPONSE_LSB = 0;
  localparam int REC_SEL_BIT = 6;
  localparam int REC_AAR_BIT = 3;
  localparam int REC_ASR_BIT = 2;
  localparam int REC_GAIN_LSB = 0;
  // Serial frame: read flag, 6-bit address, spare bit, 8-bit data
  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] ADDR_DONE_BITS = 5'd7;
  // Timing
  localparam int CLK_KHZ = 40000;
  localparam int DEG0_NS = 200;
  localparam int DEG1_NS = 600;
  localparam int DEG2_NS = 1250;
  localparam int DEG3_NS = 1600;
  localparam logic [6:0] DEG0_CYC = 7'((DEG0_NS * CLK_KHZ + 999999) / 1000000);
  localparam logic [6:0] DEG1_CYC = 7'((DEG1_NS * CLK_KHZ + 999999) / 1000000);
  localparam logic [6:0] DEG2_CYC = 7'((DEG2_NS * CLK_KHZ + 999999) / 1000000);
  localparam logic [6:0] DEG3_CYC = 7'((DEG3_NS * CLK_KHZ + 999999) / 1000000);
  localparam int RETRY_SHORT_MS = 5;
  localparam int RETRY_LONG_MS = 500;
  localparam int RETRY_W = 25;
  typedef enum logic [1:0] {
    OCR_LATCH = 2'b00,
    OCR_RETRY = 2'b01,
    OCR_REPORT = 2'b10,
    OCR_IGNORE = 2'b11
  } mdc_ocp_resp_e;
endpackage

// [include/mdc_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mdc_cfg_if;
  logic wr_pulse;
  logic err_pulse;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] status;
  modport engine (output wr_pulse, output err_pulse, output addr, output wdata,
                  input rdata, input status);
  modport regs (input wr_pulse, input err_pulse, input addr, input wdata,
                output rdata, output status);
endinterface
`default_nettype wire

// [rtl/mdc_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
module mdc_serial_port
  import mdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial pins, sampled as synchronous levels
  input wire logic scs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo_bit,
  // Register side
  mdc_cfg_if.engine cfg
);
  logic sclk_q_reg;
  logic scs_n_q_reg;
  logic [4:0] cnt_reg;
  logic [15:0] shift_reg;
  logic [7:0] rd_hold_reg;
  logic sdo_reg;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [4:0] cnt_next;

  // Edge detection on the sampled pins
  assign rise = ~scs_n & sclk & ~sclk_q_reg;
  assign fall = ~scs_n & ~sclk & sclk_q_reg;
  assign start = ~scs_n & scs_n_q_reg;
  assign stop = scs_n & ~scs_n_q_reg;
  assign cnt_next = cnt_reg + 5'd1;
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q_reg <= 1'b0;
      scs_n_q_reg <= 1'b1;
    end else begin
      sclk_q_reg <= sclk;
      scs_n_q_reg <= scs_n;
    end
  end

  // Input shifter, MSB first on rising clock; extra bits are dropped
  always_ff @(posedge clk) begin
    if (srst || start) begin
      cnt_reg <= 5'd0;
      shift_reg <= 16'h0000;
    end else if (rise && cnt_reg != FRAME_BITS) begin
      cnt_reg <= cnt_next;
      shift_reg <= {shift_reg[14:0], sdi};
    end
  end

  // Read data is frozen once the address is complete
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_hold_reg <= 8'h00;
    end else if (cnt_reg == ADDR_DONE_BITS) begin
      rd_hold_reg <= cfg.rdata;
    end
  end

  // Status byte, then register data, on falling clock
  always_ff @(posedge clk) begin
    if (srst) begin
      sdo_reg <= 1'b0;
    end else if (start) begin
      sdo_reg <= cfg.status[7];
    end else if (fall) begin
      if (cnt_reg < 5'd8) begin
        sdo_reg <= cfg.status[3'(5'd7 - cnt_reg)];
      end else if (cnt_reg < FRAME_BITS) begin
        sdo_reg <= rd_hold_reg[3'(5'd15 - cnt_reg)];
      end else begin
        sdo_reg <= 1'b0;
      end
    end
  end

  // Only a whole frame with read flag clear is a write
  assign sdo_bit = sdo_reg;
  assign cfg.addr = (cnt_reg == FRAME_BITS) ? shift_reg[14:9] : shift_reg[5:0];
  assign cfg.wdata = shift_reg[7:0];
  assign cfg.wr_pulse = stop & (cnt_reg == FRAME_BITS) & ~shift_reg[15];
  assign cfg.err_pulse = stop & (cnt_reg != FRAME_BITS);
endmodule
`default_nettype wire

// [rtl/mdc_overcurrent_guard.sv]
`timescale 1ns/1ps
`default_nettype none
module mdc_overcurrent_guard
  import mdc_pkg::*;
#(
  parameter int RETRY_SHORT_CYC = RETRY_SHORT_MS * CLK_KHZ,
  parameter int RETRY_LONG_CYC = RETRY_LONG_MS * CLK_KHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Comparator, PWM and fault clear events
  input wire logic oc_raw,
  input wire logic pwm_cycle_start,
  input wire logic clear_faults,
  // Settings
  input wire logic [1:0] filter_time,
  input wire logic retry_long,
  input wire logic cycle_clear_en,
  input wire mdc_ocp_resp_e response,
  // Results
  output logic oc_shutdown,
  output logic oc_reported
);
  logic [6:0] deg_cnt_reg;
  logic [6:0] deg_target;
  logic [RETRY_W-1:0] retry_cnt_reg;
  logic active_reg;
  logic report_reg;
  logic trip;
  logic retry_done;

  // Deglitch target by filter code
  always_comb begin
    case (filter_time)
      2'd0: deg_target = DEG0_CYC;
      2'd1: deg_target = DEG1_CYC;
      2'd2: deg_target = DEG2_CYC;
      default: deg_target = DEG3_CYC;
    endcase
  end

  // Raw must stay high for the whole filter time; trips once per episode
  always_ff @(posedge clk) begin
    if (srst || !oc_raw) begin
      deg_cnt_reg <= 7'd0;
    end else if (deg_cnt_reg != deg_target) begin
      deg_cnt_reg <= deg_cnt_reg + 7'd1;
    end
  end
  assign trip = oc_raw & (deg_cnt_reg == deg_target - 7'd1);

  // Retry wait counts down after a trip
  assign retry_done = active_reg && response == OCR_RETRY && retry_cnt_reg == '0;
  always_ff @(posedge clk) begin
    if (srst) begin
      retry_cnt_reg <= '0;
    end else if (trip) begin
      retry_cnt_reg <= retry_long ? RETRY_W'(RETRY_LONG_CYC - 1)
                                  : RETRY_W'(RETRY_SHORT_CYC - 1);
    end else if (retry_cnt_reg != '0) begin
      retry_cnt_reg <= retry_cnt_reg - 1'b1;
    end
  end

  // Fault state; a new trip wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      active_reg <= 1'b0;
      report_reg <= 1'b0;
    end else begin
      if (clear_faults || retry_done) begin
        active_reg <= 1'b0;
        report_reg <= 1'b0;
      end else if (cycle_clear_en && pwm_cycle_start) begin
        active_reg <= 1'b0;
      end
      if (trip) begin
        case (response)
          OCR_LATCH, OCR_RETRY: begin
            active_reg <= 1'b1;
            report_reg <= 1'b1;
          end
          OCR_REPORT: report_reg <= 1'b1;
          default: ;
        endcase
      end
    end
  end
  assign oc_shutdown = active_reg;
  assign oc_reported = report_reg;
endmodule
`default_nettype wire

// [rtl/mdc_ctrl_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_regs
  import mdc_pkg::*;
#(
  parameter int RETRY_SHORT_CYC = RETRY_SHORT_MS * CLK_KHZ,
  parameter int RETRY_LONG_CYC = RETRY_LONG_MS * CLK_KHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial configuration port
  input wire logic scs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  // Analog and timing events
  input wire logic overcurrent_detect,
  input wire logic supply_overvoltage,
  input wire logic thermal_warning,
  input wire logic pwm_cycle_start,
  // Drive stage settings
  output logic [1:0] slew_rate_code,
  output logic [1:0] pwm_input_scheme,
  output logic current_limit_enable,
  output logic three_input_mode,
  output logic full_duty_freq_sel,
  output logic limit_recirculation_select,
  output logic async_rectify_enable,
  output logic sync_rectify_enable,
  output logic [1:0] sense_amp_gain,
  // Protection settings
  output logic supply_overvoltage_threshold,
  output logic overvoltage_guard_enable,
  output logic overcurrent_threshold,
  // Protection results
  output logic power_stage_hiz,
  output logic fault_clear,
  output logic serial_fault,
  output logic overcurrent_fault,
  output logic fault_output_pin_n
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  mdc_cfg_if cfg ();
  logic [7:0] drive_setup_control_reg;
  logic [7:0] protection_reporting_control_reg;
  logic [7:0] overcurrent_control_reg;
  logic [7:0] recirculation_sense_control_reg;
  logic [2:0] lock_field_reg;
  logic locked_reg;
  logic fault_clear_reg;
  logic serial_fault_reg;
  logic hiz_reg;
  logic fault_pin_n_reg;
  logic [7:0] drive_setup_control_next;
  logic [7:0] protection_reporting_control_next;
  logic [7:0] overcurrent_control_next;
  logic [7:0] recirculation_sense_control_next;
  logic sdo_bit;
  logic wr_lock;
  logic wr_open;
  logic clear_now;
  logic oc_shutdown;
  logic oc_reported;
  logic ov_trip;
  logic fault_any;
  logic [7:0] rdata;

  // ----------------------------------------
  // Serial frame engine
  // ----------------------------------------
  mdc_serial_port u_port (
    .clk (clk),
    .srst (srst),
    .scs_n (scs_n),
    .sclk (sclk),
    .sdi (sdi),
    .sdo_bit (sdo_bit),
    .cfg (cfg.engine)
  );

  // Pin drive follows the drive select bit; released outside frames
  always_comb begin
    if (drive_setup_control_reg[DRV_SDO_BIT]) begin
      sdo_o = sdo_bit;
      sdo_oe = ~scs_n;
    end else begin
      sdo_o = 1'b0;
      sdo_oe = ~scs_n & ~sdo_bit;
    end
  end

  // ----------------------------------------
  // Write qualification
  // ----------------------------------------
  // The lock field stays writable so a locked part can always be opened
  assign wr_lock = cfg.wr_pulse && cfg.addr == ADDR_LOCK;
  assign wr_open = cfg.wr_pulse && !locked_reg;

  // Lock field and lock state
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_field_reg <= 3'h0;
      locked_reg <= 1'b0;
    end else if (wr_lock) begin
      lock_field_reg <= cfg.wdata[2:0];
      if (cfg.wdata[2:0] == LOCK_CODE) begin
        locked_reg <= 1'b1;
      end else if (cfg.wdata[2:0] == UNLOCK_CODE) begin
        locked_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Next values: only writable bits move
  always_comb begin
    drive_setup_control_next = drive_setup_control_reg;
    protection_reporting_control_next = protection_reporting_control_reg;
    overcurrent_control_next = overcurrent_control_reg;
    recirculation_sense_control_next = recirculation_sense_control_reg;
    if (wr_open && cfg.addr == ADDR_DRIVE) begin
      drive_setup_control_next = cfg.wdata & WMASK_DRIVE;
    end else if (wr_open && cfg.addr == ADDR_PROT) begin
      protection_reporting_control_next = cfg.wdata & WMASK_PROT;
    end else if (wr_open && cfg.addr == ADDR_OCP) begin
      overcurrent_control_next = cfg.wdata;
    end else if (wr_open && cfg.addr == ADDR_RECIR) begin
      recirculation_sense_control_next = cfg.wdata;
    end
  end

  // Drive setup register
  always_ff @(posedge clk) begin
    if (srst) begin
      drive_setup_control_reg <= RST_DRIVE;
    end else begin
      drive_setup_control_reg <= drive_setup_control_next;
    end
  end

  // Protection and reporting register
  always_ff @(posedge clk) begin
    if (srst) begin
      protection_reporting_control_reg <= RST_PROT;
    end else begin
      protection_reporting_control_reg <= protection_reporting_control_next;
    end
  end

  // Overcurrent register
  always_ff @(posedge clk) begin
    if (srst) begin
      overcurrent_control_reg <= RST_OCP;
    end else begin
      overcurrent_control_reg <= overcurrent_control_next;
    end
  end

  // Recirculation and sense register
  always_ff @(posedge clk) begin
    if (srst) begin
      recirculation_sense_control_reg <= RST_RECIR;
    end else begin
      recirculation_sense_control_reg <= recirculation_sense_control_next;
    end
  end

  // ----------------------------------------
  // Fault clear command
  // ----------------------------------------
  // The clear bit is never stored, so it reads 0 and a 0 write is inert
  assign clear_now = wr_open && cfg.addr == ADDR_DRIVE
                     && cfg.wdata[DRV_CLR_BIT];
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_clear_reg <= 1'b0;
    end else begin
      fault_clear_reg <= clear_now;
    end
  end

  // Serial frame error, latched; a new error beats a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_fault_reg <= 1'b0;
    end else if (cfg.err_pulse) begin
      serial_fault_reg <= 1'b1;
    end else if (fault_clear_reg) begin
      serial_fault_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Overcurrent handling
  // ----------------------------------------
  mdc_overcurrent_guard #(
    .RETRY_SHORT_CYC (RETRY_SHORT_CYC),
    .RETRY_LONG_CYC (RETRY_LONG_CYC)
  ) u_ocp (
    .clk (clk),
    .srst (srst),
    .oc_raw (overcurrent_detect),
    .pwm_cycle_start (pwm_cycle_start),
    .clear_faults (fault_clear_reg),
    .filter_time (overcurrent_control_reg[OVERCURRENT_FILTER_TIME_LSB +: 2]),
    .retry_long (overcurrent_control_reg[OVERCURRENT_RETRY_INTERVAL_BIT]),
    .cycle_clear_en (overcurrent_control_reg[OVERCURRENT_CYCLE_CLEAR_BIT]),
    .response (mdc_ocp_resp_e'(overcurrent_control_reg[OVERCURRENT_RESPONSE_LSB +: 2])),
    .oc_shutdown (oc_shutdown),
    .oc_reported (oc_reported)
  );

  // ----------------------------------------
  // Power stage and fault pin
  // ----------------------------------------
  // Overvoltage acts only while the guard is on
  assign ov_trip = supply_overvoltage
                   & protection_reporting_control_reg[PROT_OVEN_BIT];

  // Shutoff, overcurrent or overvoltage opens every transistor
  always_ff @(posedge clk) begin
    if (srst) begin
      hiz_reg <= 1'b1;
    end else begin
      hiz_reg <= overcurrent_control_reg[OCP_OFF_BIT]
                 | oc_shutdown | ov_trip;
    end
  end

  // Fault sources; serial and thermal ones gated by their reporting bits
  assign fault_any = oc_reported
    | ov_trip
    | (serial_fault_reg & ~protection_reporting_control_reg[PROT_SERR_BIT])
    | (thermal_warning & protection_reporting_control_reg[PROT_OTW_BIT]);

  // Registered so the pin never glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_pin_n_reg <= 1'b1;
    end else begin
      fault_pin_n_reg <= ~fault_any;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    if (cfg.addr == ADDR_LOCK) begin
      rdata = {5'h00, lock_field_reg};
    end else if (cfg.addr == ADDR_DRIVE) begin
      rdata = drive_setup_control_reg;
    end else if (cfg.addr == ADDR_PROT) begin
      rdata = protection_reporting_control_reg;
    end else if (cfg.addr == ADDR_OCP) begin
      rdata = overcurrent_control_reg;
    end else if (cfg.addr == ADDR_RECIR) begin
      rdata = recirculation_sense_control_reg;
    end else begin
      rdata = 8'h00;
    end
  end
  assign cfg.rdata = rdata;
  assign cfg.status = {4'h0, locked_reg, ov_trip, serial_fault_reg, oc_reported};

  // ----------------------------------------
  // Setting outputs
  // ----------------------------------------
  // Direct register fields for the analog side
  assign slew_rate_code = drive_setup_control_reg[DRV_SLEW_LSB +: 2];
  assign pwm_input_scheme = drive_setup_control_reg[DRV_PWM_LSB +: 2];
  assign current_limit_enable = drive_setup_control_reg[DRV_PWM_LSB];
  assign three_input_mode = drive_setup_control_reg[DRV_PWM_LSB + 1];
  assign full_duty_freq_sel = protection_reporting_control_reg[PROT_FULL_BIT];
  assign supply_overvoltage_threshold =
    protection_reporting_control_reg[PROT_OVSEL_BIT];
  assign overvoltage_guard_enable = protection_reporting_control_reg[PROT_OVEN_BIT];
  assign overcurrent_threshold = overcurrent_control_reg[OVERCURRENT_THRESHOLD_BIT];
  assign limit_recirculation_select =
    recirculation_sense_control_reg[REC_SEL_BIT];
  assign async_rectify_enable = recirculation_sense_control_reg[REC_AAR_BIT];
  assign sync_rectify_enable = recirculation_sense_control_reg[REC_ASR_BIT];
  assign sense_amp_gain = recirculation_sense_control_reg[REC_GAIN_LSB +: 2];
  assign power_stage_hiz = hiz_reg;
  assign fault_clear = fault_clear_reg;
  assign serial_fault = serial_fault_reg;
  assign overcurrent_fault = oc_reported;
  assign fault_output_pin_n = fault_pin_n_reg;
endmodule
`default_nettype wire

// [bench/mdc_ctrl_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// Port checks for the register bank
// ---------------------------------
module mdc_ctrl_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched inputs
  input wire logic scs_n,
  input wire logic overcurrent_detect,
  input wire logic supply_overvoltage,
  // Watched outputs
  input wire logic sdo_oe,
  input wire logic [1:0] slew_rate_code,
  input wire logic [1:0] pwm_input_scheme,
  input wire logic current_limit_enable,
  input wire logic three_input_mode,
  input wire logic [1:0] sense_amp_gain,
  input wire logic overvoltage_guard_enable,
  input wire logic power_stage_hiz,
  input wire logic fault_clear,
  input wire logic serial_fault,
  input wire logic overcurrent_fault,
  input wire logic fault_output_pin_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Data out is released once the frame is over
  property p_sdo_idle; scs_n && $past(scs_n) && $past(scs_n, 2) |-> !sdo_oe; endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("data out driven idle");
  // Scheme decode, both halves
  property p_lim; current_limit_enable == pwm_input_scheme[0]; endproperty
  a_lim: assert property (p_lim) else $error("limit decode wrong");
  property p_three; three_input_mode == pwm_input_scheme[1]; endproperty
  a_three: assert property (p_three) else $error("three input decode wrong");
  // Clear strobe is one cycle and empties the latch
  property p_fc_pulse; fault_clear |=> !fault_clear; endproperty
  a_fc_pulse: assert property (p_fc_pulse) else $error("clear strobe too long");
  property p_fc_clears;
    fault_clear && !overcurrent_detect ##1 !overcurrent_detect |=> !overcurrent_fault;
  endproperty
  a_fc_clears: assert property (p_fc_clears) else $error("report survived clear");
  // Latched serial error only leaves through a clear
  property p_sticky; serial_fault && !fault_clear |=> serial_fault; endproperty
  a_sticky: assert property (p_sticky) else $error("serial error dropped");
  // Guarded overvoltage shuts the stage and pulls the pin
  property p_ovp;
    supply_overvoltage && overvoltage_guard_enable |=> power_stage_hiz && !fault_output_pin_n;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage not acted on");
  // Settings leave reset at their default codes
  property p_rst;
    $fell(srst) |-> slew_rate_code == 2'h0 && sense_amp_gain == 2'h0 && overvoltage_guard_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset settings wrong");
  // A report needs the comparator high four cycles before it rises
  property p_filt; $rose(overcurrent_fault) |-> $past(overcurrent_detect, 4); endproperty
  a_filt: assert property (p_filt) else $error("report without filter");
endmodule
bind mdc_ctrl_regs mdc_ctrl_regs_checker u_chk (.clk, .srst, .scs_n, .overcurrent_detect,
  .supply_overvoltage, .sdo_oe,
  .slew_rate_code, .pwm_input_scheme, .current_limit_enable, .three_input_mode,
  .sense_amp_gain, .overvoltage_guard_enable, .power_stage_hiz, .fault_clear,
  .serial_fault, .overcurrent_fault, .fault_output_pin_n);
`default_nettype wire

// [bench/mdc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mdc_host_model (
  // Clock and device data out
  input wire logic clk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  // Frame lines, serial clock still between frames
  output logic scs_n,
  output logic sclk,
  output logic sdi
);
  // Pull-up holds the undriven line
  wire logic sdo_line = sdo_oe ? sdo_o : 1'b1;
  initial begin
    scs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // MSB first, two cycles per phase; short n makes a bad frame
  task automatic xfer(input logic [15:0] f, input int n, output logic [15:0] r);
    r = 16'h0000;
    scs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi <= f[15 - i];
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      r = {r[14:0], sdo_line};
      sclk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    scs_n <= 1'b1;
    sdi <= ~sdi; // Released line shows no stale bit
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [bench/mdc_ctrl_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_regs_tb
  import mdc_pkg::*;
;
  logic clk, srst, overcurrent_detect, supply_overvoltage, thermal_warning, pwm_cycle_start;
  logic scs_n, sclk, sdi, sdo_o, sdo_oe, current_limit_enable, three_input_mode;
  logic full_duty_freq_sel, limit_recirculation_select, async_rectify_enable;
  logic sync_rectify_enable, supply_overvoltage_threshold, overvoltage_guard_enable;
  logic overcurrent_threshold, power_stage_hiz, fault_clear, serial_fault;
  logic overcurrent_fault, fault_output_pin_n;
  logic [1:0] slew_rate_code, pwm_input_scheme, sense_amp_gain;
  int fail_count = 0;
  int checks_done = 0;
  // Short retry waits keep the run brief
  mdc_ctrl_regs #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(40)) dut (.*);
  mdc_host_model host (.clk, .sdo_o, .sdo_oe, .scs_n, .sclk, .sdi);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({1'b0, a, 1'b0, d}, 16, r);
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [15:0] r;
    host.xfer({1'b1, a, 9'h000}, 16, r);
    chk(r[7:0], e);
  endtask
  // Hold comparator n cycles, compare hiz and report
  task automatic trip(input int n, input logic [1:0] e);
    if (n > 0) overcurrent_detect <= 1'b1;
    repeat (n) @(posedge clk);
    overcurrent_detect <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h00, power_stage_hiz, overcurrent_fault}, {6'h00, e});
  endtask
  task automatic pulse(input logic [1:0] e);
    pwm_cycle_start <= 1'b1;
    @(posedge clk);
    pwm_cycle_start <= 1'b0;
    repeat (2) @(posedge clk);
    chk({6'h00, power_stage_hiz, overcurrent_fault}, {6'h00, e});
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    logic [1:0] v;
    logic [15:0] r;
    srst = 1'b1;
    {overcurrent_detect, supply_overvoltage, thermal_warning, pwm_cycle_start} = 4'h0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc(ADDR_DRIVE, RST_DRIVE);
    rc(ADDR_PROT, RST_PROT);
    rc(ADDR_OCP, RST_OCP);
    rc(ADDR_RECIR, RST_RECIR);
    chk({slew_rate_code, sense_amp_gain, pwm_input_scheme, overvoltage_guard_enable,
         supply_overvoltage_threshold}, 8'h02);
    // Every code of each field reaches its port; the full-duty bit is only checked at 1
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      wr(ADDR_DRIVE, {3'b111, v, v, 1'b0});
      wr(ADDR_OCP, {2'b00, v, i[0], i[1], v});
      wr(ADDR_RECIR, {1'b0, i[0], 2'b00, i[1], i[0], v});
      wr(ADDR_PROT, {4'hf, i[0], i[1], i[0], i[1]});
      chk({slew_rate_code, pwm_input_scheme, sense_amp_gain, overcurrent_threshold,
           limit_recirculation_select}, {v, v, v, i[1], i[0]});
      chk({full_duty_freq_sel, supply_overvoltage_threshold, overvoltage_guard_enable,
           async_rectify_enable, sync_rectify_enable, 3'h0}, {1'b1, i[0], i[1], i[1], i[0], 3'h0});
      rc(ADDR_PROT, {4'h7, i[0], i[1], i[0], i[1]});
      rc(ADDR_OCP, {2'b00, v, i[0], i[1], v});
    end
    thermal_warning <= 1'b1;
    repeat (3) @(posedge clk);
    chk(8'(fault_output_pin_n), 8'h00);
    wr(ADDR_PROT, 8'h46);
    chk(8'(fault_output_pin_n), 8'h01);
    thermal_warning <= 1'b0;
    supply_overvoltage <= 1'b1;
    repeat (3) @(posedge clk);
    chk(8'(power_stage_hiz), 8'h01);
    wr(ADDR_PROT, 8'h42);
    chk(8'(power_stage_hiz), 8'h00);
    supply_overvoltage <= 1'b0;
    wr(ADDR_OCP, 8'h80);
    chk(8'(power_stage_hiz), 8'h01);
    wr(ADDR_OCP, 8'h00);
    trip(12, 2'b11);
    pulse(2'b11);
    wr(ADDR_DRIVE, 8'he0);
    chk(8'(overcurrent_fault), 8'h01);
    wr(ADDR_DRIVE, 8'he1);
    chk(8'(overcurrent_fault), 8'h00);
    rc(ADDR_DRIVE, 8'he0);
    wr(ADDR_OCP, 8'h40);
    trip(12, 2'b11);
    pulse(2'b01);
    wr(ADDR_DRIVE, 8'he1);
    wr(ADDR_OCP, 8'h02);
    trip(12, 2'b01);
    wr(ADDR_DRIVE, 8'he1);
    wr(ADDR_OCP, 8'h03);
    trip(12, 2'b00);
    wr(ADDR_OCP, 8'h30);
    trip(60, 2'b00);
    trip(70, 2'b11);
    wr(ADDR_DRIVE, 8'he1);
    wr(ADDR_OCP, 8'h01);
    trip(12, 2'b11);
    repeat (20) @(posedge clk);
    trip(0, 2'b00);
    wr(ADDR_OCP, 8'h09);
    trip(12, 2'b11);
    repeat (20) @(posedge clk);
    trip(0, 2'b11);
    repeat (20) @(posedge clk);
    trip(0, 2'b00);
    // Bad frame length latches a serial error
    host.xfer(16'h0000, 15, r);
    chk({6'h00, serial_fault, fault_output_pin_n}, 8'h03);
    wr(ADDR_PROT, 8'h40);
    chk(8'(fault_output_pin_n), 8'h00);
    wr(ADDR_DRIVE, 8'he1);
    chk(8'(serial_fault), 8'h00);
    wr(ADDR_LOCK, {5'h00, LOCK_CODE});
    wr(ADDR_RECIR, 8'h00);
    rc(ADDR_RECIR, 8'h4f);
    wr(ADDR_LOCK, {5'h00, UNLOCK_CODE});
    wr(ADDR_RECIR, 8'h00);
    rc(ADDR_RECIR, 8'h00);
    // Open drain read relies on the pull-up for ones
    wr(ADDR_DRIVE, 8'hc0);
    rc(ADDR_OCP, 8'h09);
    rc(ADDR_DRIVE, 8'hc0);
    end_of_test();
  end
endmodule
`default_nettype wire
